//--- rtl/tw_pkg.sv
// Constants shared by the two-wire interface block
package tw_pkg;
	// Register addresses on the special-function register port
	localparam logic [7:0] ADDR_DATA = 8'h9a;
	localparam logic [7:0] ADDR_SADDR = 8'h9b;
	localparam logic [7:0] ADDR_CTRL = 8'he8;
	// Reset values
	localparam logic [7:0] RST_DATA = 8'h00;
	localparam logic [7:0] RST_SADDR = 8'h55;
	localparam logic [7:0] RST_CTRL = 8'h00;
	// Control register field positions
	localparam int B_SW_DATA_OUT = 7;
	localparam int B_SW_DATA_DRIVE = 6;
	localparam int B_SW_CLOCK_OUT = 5;
	localparam int B_SW_DATA_IN = 4;
	localparam int B_ROLE = 3;
	localparam int B_SLAVE_RESET = 2;
	localparam int B_SLAVE_DIR = 1;
	localparam int B_BYTE_DONE = 0;
	// Bits of the control register that software may write
	localparam logic [7:0] CTRL_WMASK = 8'hec;
	// Port-select bit inside the SPI control register
	localparam int B_PORT_SELECT = 5;
	// Bits per byte and idle level of the bus lines
	localparam logic [3:0] BITS_PER_BYTE = 4'h8;
	localparam logic PIN_IDLE = 1'b1;
	// Slave protocol states
	typedef enum logic [2:0] {
		S_IDLE,
		S_ADDR,
		S_AACK,
		S_RX,
		S_RACK,
		S_TX,
		S_TACK
	} tw_state_t;
endpackage

//--- rtl/tw_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
`default_nettype none
module tw_sync
	import tw_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Pin in, filtered level out
	input wire logic pin,
	output logic level
);
	logic s1_r, s2_r, s3_r, lvl_r;
	logic lvl_nxt;

	// Only the second stage reads the first
	always_comb begin
		lvl_nxt = (s2_r == s3_r) ? s3_r : lvl_r;
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			s1_r <= PIN_IDLE;
			s2_r <= PIN_IDLE;
			s3_r <= PIN_IDLE;
			lvl_r <= PIN_IDLE;
		end else begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			lvl_r <= lvl_nxt;
		end
	end

	assign level = lvl_r;
endmodule
`default_nettype wire

//--- rtl/tw_buf.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none
module tw_buf #(
	parameter int W = 8
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	logic [W-1:0] mem_r [2];
	logic wp_r, rp_r, wp_nxt, rp_nxt;
	logic [1:0] cnt_r, cnt_nxt;
	logic push, pop;

	assign in_ready = (cnt_r != 2'h2);
	assign out_valid = (cnt_r != 2'h0);
	assign out_data = mem_r[rp_r];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wp_nxt = push ? ~wp_r : wp_r;
		rp_nxt = pop ? ~rp_r : rp_r;
		cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			wp_r <= 1'b0;
			rp_r <= 1'b0;
			cnt_r <= 2'h0;
		end else begin
			wp_r <= wp_nxt;
			rp_r <= rp_nxt;
			cnt_r <= cnt_nxt;
		end
	end

	// Storage needs no reset; valid gates it
	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	a_buf_bound: assert property (@(posedge clk_sys) disable iff (!rstn) cnt_r != 2'h3)
		else $error("buffer count out of range");
endmodule
`default_nettype wire

//--- rtl/tw_top.sv
// Two-wire interface: software-driven master, hardware slave, register port
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - The interface shares its clock and data pins with the SPI block, so only one owns them.
// - A zero in bit 5 of the SPI control register hands the shared pins to this interface.
// - Two roles exist: a software-driven master and a hardware slave.
// - In master mode the data-out bit appears on the data pin while data drive is enabled.
// - In master mode the data-drive bit makes the data pin an output when set, input when clear.
// - In master mode the clock-out bit is driven straight onto the clock pin.
// - In master mode with data drive off, the clock latches the data pin into the data-in bit.
// - The role bit selects master when set and slave when clear.
// - In slave mode the interface is held in reset while the slave reset bit is one.
// - In slave mode the direction flag is set while transmitting and clear while receiving.
// - In slave mode the byte-done flag is set after each data byte sent or accepted, not after the address byte or a refused byte.
// - Any access to the data register clears the byte-done flag.
// - The slave address register holds the 7-bit address, resets to 55H and is writable.
// - A written data byte is the next one sent; a read returns the oldest unread byte received.
module tw_top
	import tw_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rstn,
	// Special-function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// SPI control register, for pin ownership
	input wire logic [7:0] serial_periph_control,
	output logic twi_owns_pins,
	// Shared clock pin, open drain
	input wire logic serial_clock_pin_in,
	output logic serial_clock_pin_out,
	output logic serial_clock_pin_oe,
	// Shared data pin, open drain
	input wire logic serial_data_pin_in,
	output logic serial_data_pin_out,
	output logic serial_data_pin_oe
);
	logic scl_lvl, sda_lvl, scl_prev_r, sda_prev_r;
	logic scl_rise, scl_fall, sda_rise, sda_fall, start_evt, stop_evt;
	logic owns, master, slave_run, dat_acc;
	logic [7:0] ctl_r, ctl_nxt, sadr_r, sadr_nxt, txd_r, txd_nxt, rxd_r, rxd_nxt;
	logic [7:0] rdata_r, rdata_nxt;
	logic rx_full_r, rx_full_nxt;
	tw_state_t state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	logic rw_r, rw_nxt, ack_ok_r, ack_ok_nxt, sda_drv_r, sda_drv_nxt;
	logic byte_evt, rx_push;
	logic scl_oe_r, scl_oe_nxt, sda_oe_r, sda_oe_nxt, owns_r;
	logic buf_in_ready, buf_out_valid;
	logic [7:0] buf_out_data;

	tw_sync u_scl_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin(serial_clock_pin_in),
		.level(scl_lvl)
	);

	tw_sync u_sda_sync (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.pin(serial_data_pin_in),
		.level(sda_lvl)
	);

	// Received bytes wait here so a slow reader loses none
	tw_buf #(.W(8)) u_rx_buf (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.in_valid(rx_push),
		.in_ready(buf_in_ready),
		.in_data({shift_r[6:0], sda_lvl}),
		.out_valid(buf_out_valid),
		.out_ready(!rx_full_r),
		.out_data(buf_out_data)
	);

	assign scl_rise = scl_lvl && !scl_prev_r;
	assign scl_fall = !scl_lvl && scl_prev_r;
	assign sda_rise = sda_lvl && !sda_prev_r;
	assign sda_fall = !sda_lvl && sda_prev_r;
	// Clock high for two samples, so a data edge landing with the clock rise is no event
	assign start_evt = sda_fall && scl_lvl && scl_prev_r;
	assign stop_evt = sda_rise && scl_lvl && scl_prev_r;
	assign owns = !serial_periph_control[B_PORT_SELECT];
	assign master = ctl_r[B_ROLE];
	assign slave_run = owns && !master && !ctl_r[B_SLAVE_RESET];
	assign dat_acc = (sfr_wr || sfr_rd) && (sfr_addr == ADDR_DATA);

	// Slave protocol engine
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		cnt_nxt = cnt_r;
		rw_nxt = rw_r;
		ack_ok_nxt = ack_ok_r;
		sda_drv_nxt = sda_drv_r;
		byte_evt = 1'b0;
		rx_push = 1'b0;
		if (!slave_run) begin
			state_nxt = S_IDLE;
			sda_drv_nxt = 1'b0;
		end else if (stop_evt) begin
			state_nxt = S_IDLE;
			sda_drv_nxt = 1'b0;
		end else if (start_evt) begin
			state_nxt = S_ADDR;
			cnt_nxt = 4'h0;
			sda_drv_nxt = 1'b0;
		end else begin
			unique case (state_r)
				S_IDLE: begin
				end
				S_ADDR: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_lvl};
						cnt_nxt = cnt_r + 4'h1;
					end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
						if (shift_r[7:1] == sadr_r[6:0]) begin
							state_nxt = S_AACK;
							sda_drv_nxt = 1'b1;
							rw_nxt = shift_r[0];
						end else begin
							state_nxt = S_IDLE;
						end
					end
				end
				S_AACK: begin
					if (scl_fall) begin
						cnt_nxt = 4'h0;
						if (rw_r) begin
							state_nxt = S_TX;
							shift_nxt = txd_r;
							sda_drv_nxt = !txd_r[7];
						end else begin
							state_nxt = S_RX;
							sda_drv_nxt = 1'b0;
						end
					end
				end
				S_RX: begin
					if (scl_rise) begin
						shift_nxt = {shift_r[6:0], sda_lvl};
						cnt_nxt = cnt_r + 4'h1;
						if (cnt_r == BITS_PER_BYTE - 4'h1) begin
							rx_push = 1'b1;
							byte_evt = buf_in_ready;
							ack_ok_nxt = buf_in_ready;
						end
					end else if (scl_fall && cnt_r == BITS_PER_BYTE) begin
						// Full buffer answers with a refusal, not a lost byte
						state_nxt = ack_ok_r ? S_RACK : S_IDLE;
						sda_drv_nxt = ack_ok_r;
					end
				end
				S_RACK: begin
					if (scl_fall) begin
						state_nxt = S_RX;
						cnt_nxt = 4'h0;
						sda_drv_nxt = 1'b0;
					end
				end
				S_TX: begin
					if (scl_rise) begin
						cnt_nxt = cnt_r + 4'h1;
						byte_evt = (cnt_r == BITS_PER_BYTE - 4'h1);
					end else if (scl_fall) begin
						if (cnt_r == BITS_PER_BYTE) begin
							state_nxt = S_TACK;
							sda_drv_nxt = 1'b0;
						end else begin
							shift_nxt = {shift_r[6:0], 1'b0};
							sda_drv_nxt = !shift_r[6];
						end
					end
				end
				S_TACK: begin
					if (scl_rise && sda_lvl) begin
						state_nxt = S_IDLE;
					end else if (scl_fall) begin
						state_nxt = S_TX;
						cnt_nxt = 4'h0;
						shift_nxt = txd_r;
						sda_drv_nxt = !txd_r[7];
					end
				end
			endcase
		end
	end

	// Registers, pins and read port
	always_comb begin
		ctl_nxt = ctl_r;
		sadr_nxt = sadr_r;
		txd_nxt = txd_r;
		rxd_nxt = rxd_r;
		rx_full_nxt = rx_full_r;
		rdata_nxt = rdata_r;
		if (sfr_wr && sfr_addr == ADDR_CTRL) begin
			ctl_nxt = (ctl_r & ~CTRL_WMASK) | (sfr_wdata & CTRL_WMASK);
		end
		if (sfr_wr && sfr_addr == ADDR_SADDR) begin
			sadr_nxt = sfr_wdata;
		end
		if (sfr_wr && sfr_addr == ADDR_DATA) begin
			txd_nxt = sfr_wdata;
		end
		if (sfr_rd) begin
			unique case (sfr_addr)
				ADDR_DATA: rdata_nxt = rxd_r;
				ADDR_SADDR: rdata_nxt = sadr_r;
				ADDR_CTRL: rdata_nxt = ctl_r;
				default: rdata_nxt = 8'h00;
			endcase
			if (sfr_addr == ADDR_DATA) begin
				rx_full_nxt = 1'b0;
			end
		end
		if (buf_out_valid && !rx_full_r) begin
			rxd_nxt = buf_out_data;
			rx_full_nxt = 1'b1;
		end
		if (owns && master && !ctl_r[B_SW_DATA_DRIVE] && scl_rise) begin
			ctl_nxt[B_SW_DATA_IN] = sda_lvl;
		end
		ctl_nxt[B_SLAVE_DIR] = (state_nxt == S_TX) || (state_nxt == S_TACK);
		// Set wins over the clear by a data access
		if (byte_evt) begin
			ctl_nxt[B_BYTE_DONE] = 1'b1;
		end else if (dat_acc) begin
			ctl_nxt[B_BYTE_DONE] = 1'b0;
		end
		scl_oe_nxt = owns && master && !ctl_r[B_SW_CLOCK_OUT];
		if (!owns) begin
			sda_oe_nxt = 1'b0;
		end else if (master) begin
			sda_oe_nxt = ctl_r[B_SW_DATA_DRIVE] && !ctl_r[B_SW_DATA_OUT];
		end else begin
			sda_oe_nxt = sda_drv_nxt;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_r <= S_IDLE;
			shift_r <= 8'h00;
			cnt_r <= 4'h0;
			rw_r <= 1'b0;
			ack_ok_r <= 1'b0;
			sda_drv_r <= 1'b0;
			ctl_r <= RST_CTRL;
			sadr_r <= RST_SADDR;
			txd_r <= RST_DATA;
			rxd_r <= RST_DATA;
			rx_full_r <= 1'b0;
			rdata_r <= 8'h00;
			scl_prev_r <= PIN_IDLE;
			sda_prev_r <= PIN_IDLE;
			scl_oe_r <= 1'b0;
			sda_oe_r <= 1'b0;
			owns_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			cnt_r <= cnt_nxt;
			rw_r <= rw_nxt;
			ack_ok_r <= ack_ok_nxt;
			sda_drv_r <= sda_drv_nxt;
			ctl_r <= ctl_nxt;
			sadr_r <= sadr_nxt;
			txd_r <= txd_nxt;
			rxd_r <= rxd_nxt;
			rx_full_r <= rx_full_nxt;
			rdata_r <= rdata_nxt;
			scl_prev_r <= scl_lvl;
			sda_prev_r <= sda_lvl;
			scl_oe_r <= scl_oe_nxt;
			sda_oe_r <= sda_oe_nxt;
			owns_r <= owns;
		end
	end

	assign sfr_rdata = rdata_r;
	assign twi_owns_pins = owns_r;
	// Open drain: the driven level is always low
	assign serial_clock_pin_out = 1'b0;
	assign serial_data_pin_out = 1'b0;
	assign serial_clock_pin_oe = scl_oe_r;
	assign serial_data_pin_oe = sda_oe_r;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	a_pins_released: assert property (!owns |=> !serial_clock_pin_oe && !serial_data_pin_oe)
		else $error("pins driven while SPI owns them");
	a_master_clock: assert property (owns && master |=>
		serial_clock_pin_oe == !$past(ctl_r[B_SW_CLOCK_OUT]))
		else $error("clock pin does not follow clock-out bit");
	a_master_data: assert property (owns && master |=>
		serial_data_pin_oe == ($past(ctl_r[B_SW_DATA_DRIVE]) && !$past(ctl_r[B_SW_DATA_OUT])))
		else $error("data pin does not follow data-out bit");
	a_data_input: assert property (owns && master && !ctl_r[B_SW_DATA_DRIVE] |=>
		!serial_data_pin_oe)
		else $error("data pin driven with drive disabled");
	a_data_capture: assert property (owns && master && !ctl_r[B_SW_DATA_DRIVE] && scl_rise |=>
		ctl_r[B_SW_DATA_IN] == $past(sda_lvl))
		else $error("data-in bit not captured");
	a_slave_reset: assert property (!master && ctl_r[B_SLAVE_RESET] |=>
		state_r == S_IDLE && !serial_data_pin_oe)
		else $error("slave active while held in reset");
	a_dir_flag: assert property (state_r == S_TX || state_r == S_TACK |-> ctl_r[B_SLAVE_DIR])
		else $error("direction flag clear while sending");
	a_done_set: assert property (byte_evt |=> ctl_r[B_BYTE_DONE])
		else $error("byte-done flag not set");
	a_done_clear: assert property (dat_acc && !byte_evt |=> !ctl_r[B_BYTE_DONE])
		else $error("data access left byte-done flag set");
	a_ack_drive: assert property (state_r == S_AACK |-> serial_data_pin_oe)
		else $error("address match not acknowledged");

	c_addr_read: cover property (state_r == S_AACK && rw_r);
	c_addr_write: cover property (state_r == S_AACK && !rw_r);
	c_rx_byte: cover property (rx_push && buf_in_ready);
	c_rx_refused: cover property (rx_push && !buf_in_ready);
endmodule
`default_nettype wire

//--- bench/tw_bus_master.sv
// Behavioural far-side bus master for the two-wire slave
`timescale 1ns/10ps
`default_nettype none
module tw_bus_master (
	// Resolved bus lines
	input wire logic scl_line,
	input wire logic sda_line,
	// Pull-low enables
	output logic scl_oe,
	output logic sda_oe
);
	// 800 ns period with a long low phase: the slave answers up to 500 ns after a fall
	localparam int T_LO1 = 250;
	localparam int T_LO2 = 300;
	localparam int T_HI = 250;
	initial begin
		scl_oe = 1'b0;
		sda_oe = 1'b0;
	end
	// Only ever pulls low; the pull-up gives the high level
	task automatic clock_bit(input logic b, output logic s);
		sda_oe = !b;
		#T_LO2;
		scl_oe = 1'b0;
		#(T_HI - 20);
		s = sda_line;
		#20;
		scl_oe = 1'b1;
		#T_LO1;
	endtask
	task automatic start_cond;
		sda_oe = 1'b1;
		#T_HI;
		scl_oe = 1'b1;
		#T_LO1;
	endtask
	task automatic stop_cond;
		sda_oe = 1'b1;
		#T_LO2;
		scl_oe = 1'b0;
		#T_HI;
		sda_oe = 1'b0;
		#T_HI;
	endtask
	task automatic send_byte(input logic [7:0] d, output logic nack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(d[i], s);
		end
		clock_bit(1'b1, nack);
	endtask
	task automatic get_byte(input logic nack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			clock_bit(1'b1, d[i]);
		end
		clock_bit(nack, s);
	endtask
	// Static data level for the software-master capture case
	task automatic set_data(input logic v);
		sda_oe = !v;
	endtask
endmodule
`default_nettype wire

//--- bench/tw_top_tb_top.sv
// Self-checking bench for the two-wire interface block
`timescale 1ns/10ps
`default_nettype none
module tw_top_tb_top
	import tw_pkg::*;
;
	logic clk_sys = 1'b0;
	logic rstn = 1'b0;
	logic [7:0] sfr_addr = 8'h00;
	logic sfr_wr = 1'b0;
	logic sfr_rd = 1'b0;
	logic [7:0] sfr_wdata = 8'h00;
	logic [7:0] sfr_rdata;
	logic [7:0] spi_ctrl = 8'h00;
	logic owns, scl_out, scl_oe, sda_out, sda_oe, m_scl_oe, m_sda_oe;
	wire scl_line;
	wire sda_line;
	int fail_count = 0;
	int num_checks = 0;
	assign scl_line = !(scl_oe | m_scl_oe);
	assign sda_line = !(sda_oe | m_sda_oe);
	always #50 clk_sys = ~clk_sys;
	tw_top tw_top_inst (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd),
		.sfr_wdata(sfr_wdata),
		.sfr_rdata(sfr_rdata),
		.serial_periph_control(spi_ctrl),
		.twi_owns_pins(owns),
		.serial_clock_pin_in(scl_line),
		.serial_clock_pin_out(scl_out),
		.serial_clock_pin_oe(scl_oe),
		.serial_data_pin_in(sda_line),
		.serial_data_pin_out(sda_out),
		.serial_data_pin_oe(sda_oe)
	);
	tw_bus_master tw_bus_master_inst (
		.scl_line(scl_line),
		.sda_line(sda_line),
		.scl_oe(m_scl_oe),
		.sda_oe(m_sda_oe)
	);
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		#5;
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(posedge clk_sys);
		#5;
		sfr_wr = 1'b0;
	endtask
	task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		#5;
		sfr_addr = a;
		sfr_rd = 1'b1;
		@(posedge clk_sys);
		#5;
		sfr_rd = 1'b0;
		d = sfr_rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		reg_rd(a, d);
		chk(d, exp);
	endtask
	task automatic settle;
		repeat (3) @(posedge clk_sys);
		#5;
	endtask
	task automatic t_reset_values;
		rd_chk(ADDR_DATA, RST_DATA);
		rd_chk(ADDR_SADDR, RST_SADDR);
		rd_chk(ADDR_CTRL, RST_CTRL);
		rd_chk(8'h9c, 8'h00);
		reg_wr(ADDR_SADDR, 8'h3c);
		reg_wr(8'h9c, 8'hff);
		rd_chk(ADDR_SADDR, 8'h3c);
		// Status bits belong to hardware
		reg_wr(ADDR_CTRL, 8'h13);
		rd_chk(ADDR_CTRL, 8'h00);
	endtask
	task automatic t_ownership;
		@(posedge clk_sys);
		#5;
		spi_ctrl = 8'h20;
		reg_wr(ADDR_CTRL, 8'h08);
		settle();
		chk({3'h0, scl_out, sda_out, owns, scl_oe, sda_oe}, 8'h00);
		spi_ctrl = 8'h00;
		settle();
		chk({3'h0, scl_out, sda_out, owns, scl_oe, sda_oe}, 8'h06);
	endtask
	task automatic t_master_pins;
		for (int i = 0; i < 8; i++) begin
			reg_wr(ADDR_CTRL, {i[2:0], 5'h08});
			settle();
			chk({6'h00, scl_oe, sda_oe}, {6'h00, !i[0], i[1] & !i[2]});
		end
	endtask
	task automatic t_capture;
		logic [7:0] d;
		for (int v = 0; v < 2; v++) begin
			tw_bus_master_inst.set_data(v[0]);
			reg_wr(ADDR_CTRL, 8'h08);
			// Clock must stay low past the pin filter
			settle();
			reg_wr(ADDR_CTRL, 8'h28);
			repeat (8) @(posedge clk_sys);
			reg_rd(ADDR_CTRL, d);
			chk({7'h00, d[4]}, {7'h00, v[0]});
		end
		tw_bus_master_inst.set_data(1'b1);
		reg_wr(ADDR_CTRL, 8'h00);
	endtask
	task automatic t_slave_write;
		logic nack;
		logic [7:0] dat [4] = '{8'h81, 8'h42, 8'h24, 8'h18};
		tw_bus_master_inst.start_cond();
		tw_bus_master_inst.send_byte(8'h78, nack);
		chk({7'h00, nack}, 8'h00);
		// Third byte fills data register plus buffer; fourth is refused
		for (int k = 0; k < 4; k++) begin
			tw_bus_master_inst.send_byte(dat[k], nack);
			chk({7'h00, nack}, {7'h00, k == 3});
		end
		tw_bus_master_inst.stop_cond();
		// Data-in bit keeps the last level captured as master
		rd_chk(ADDR_CTRL, 8'h11);
		rd_chk(ADDR_DATA, 8'h81);
		rd_chk(ADDR_CTRL, 8'h10);
		rd_chk(ADDR_DATA, 8'h42);
		rd_chk(ADDR_DATA, 8'h24);
		tw_bus_master_inst.start_cond();
		tw_bus_master_inst.send_byte(8'h7a, nack);
		chk({7'h00, nack}, 8'h01);
		tw_bus_master_inst.stop_cond();
	endtask
	task automatic t_slave_read;
		logic nack;
		logic [7:0] d;
		logic [7:0] c;
		reg_wr(ADDR_DATA, 8'hc3);
		tw_bus_master_inst.start_cond();
		tw_bus_master_inst.send_byte(8'h79, nack);
		chk({7'h00, nack}, 8'h00);
		fork
			tw_bus_master_inst.get_byte(1'b1, d);
			begin
				#2000;
				reg_rd(ADDR_CTRL, c);
			end
		join
		chk(d, 8'hc3);
		chk(c, 8'h12);
		reg_rd(ADDR_CTRL, c);
		chk({7'h00, c[0]}, 8'h01);
		tw_bus_master_inst.stop_cond();
		reg_wr(ADDR_DATA, 8'h00);
		rd_chk(ADDR_CTRL, 8'h10);
	endtask
	task automatic t_slave_reset;
		logic nack;
		reg_wr(ADDR_CTRL, 8'h04);
		tw_bus_master_inst.start_cond();
		tw_bus_master_inst.send_byte(8'h78, nack);
		chk({7'h00, nack}, 8'h01);
		tw_bus_master_inst.stop_cond();
		reg_wr(ADDR_CTRL, 8'h00);
		tw_bus_master_inst.start_cond();
		tw_bus_master_inst.send_byte(8'h78, nack);
		chk({7'h00, nack}, 8'h00);
		tw_bus_master_inst.stop_cond();
	endtask
	task automatic close_out;
		$display("checks %0d errors %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk_sys);
		#5;
		rstn = 1'b1;
		t_reset_values();
		t_ownership();
		t_master_pins();
		t_capture();
		t_slave_write();
		t_slave_read();
		t_slave_reset();
		close_out();
	end
	// Whole run needs well under a millisecond
	initial begin
		#3000000;
		fail_count++;
		close_out();
	end
endmodule
`default_nettype wire
